//--- verilog/i2ct_defs.vh
`ifndef I2CT_DEFS_VH
`define I2CT_DEFS_VH

// ****************************************
// bit counter marks
// ****************************************
`define I2CT_CNT_ZERO 4'h0
`define I2CT_CNT_ONE 4'h1
`define I2CT_CNT_LAST 4'h8
`define I2CT_CNT_ACK 4'h9

// ****************************************
// address byte fields
// ****************************************
`define I2CT_TEN_PREFIX 5'h1E
`define I2CT_PFX_HI 7
`define I2CT_PFX_LO 3
`define I2CT_A98_HI 2
`define I2CT_A98_LO 1
`define I2CT_A7_HI 7
`define I2CT_A7_LO 1
`define I2CT_RW_BIT 0
`define I2CT_MSB 7
`define I2CT_NEXT 6

// ****************************************
// reset values
// ****************************************
`define I2CT_BYTE_RST 8'h00
`define I2CT_ADDR_RST 8'h00
`define I2CT_CKP_RST 1'b1
`define I2CT_FLAG_RST 1'b0
`define I2CT_PIN_RST 2'h3
`define I2CT_OE_N_RST 1'b1
`define I2CT_PIN_OUT 1'b0

`endif

//--- verilog/i2ct_sync2.v
`include "i2ct_defs.vh"

// ****************************************
// two-stage synchroniser for the bus pins
// ****************************************
module i2ct_sync2 (
    input wire i_ref_clk,
    input wire i_sys_rst,
    input wire [1:0] i_async,
    output wire [1:0] o_sync
);
    reg [1:0] meta_ff;
    reg [1:0] sync_ff;

    // resets to idle-high so no false start is seen after reset
    always @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            meta_ff <= `I2CT_PIN_RST;
            sync_ff <= `I2CT_PIN_RST;
        end else begin
            meta_ff <= i_async;
            sync_ff <= meta_ff;
        end
    end

    assign o_sync = sync_ff;
endmodule

//--- verilog/i2ct_target.v
`include "i2ct_defs.vh"

module i2ct_target (
    input wire i_ref_clk,
    input wire i_sys_rst,
    input wire i_scl,
    input wire i_sda,
    input wire i_ten_bit_mode,
    input wire i_clock_stretch_enable,
    input wire i_address_hold_enable,
    input wire i_data_hold_enable,
    input wire i_target_collision_detect_enable,
    input wire i_start_irq_enable,
    input wire i_ack_data_choice,
    input wire i_addr_wr,
    input wire [7:0] i_addr_wdata,
    input wire i_buf_wr,
    input wire [7:0] i_buf_wdata,
    input wire i_buf_rd,
    input wire i_ckp_set,
    input wire i_irq_clr,
    input wire i_bcl_clr,
    output wire o_scl_o,
    output wire o_scl_oe_n,
    output wire o_sda_o,
    output wire o_sda_oe_n,
    output wire [7:0] o_rx_tx_buffer,
    output wire o_buffer_full_flag,
    output wire o_serial_irq_flag,
    output wire o_bus_collision_flag,
    output wire o_clock_release_bit,
    output wire o_ack_status_bit,
    output wire o_ack_timing_flag,
    output wire o_read_write_flag,
    output wire o_data_address_flag,
    output wire o_update_address_flag,
    output wire o_start_flag,
    output wire o_stop_flag
);
    localparam [2:0] ST_IDLE = 3'h0;
    localparam [2:0] ST_ADDR = 3'h1;
    localparam [2:0] ST_ADDR_LO = 3'h2;
    localparam [2:0] ST_RX = 3'h3;
    localparam [2:0] ST_TX = 3'h4;
    localparam [2:0] ST_WAIT = 3'h5;

    // ****************************************
    // pin sampling and bus events
    // ****************************************
    wire [1:0] pins_s;
    wire scl_s;
    wire sda_s;
    reg scl_q_ff, sda_q_ff;

    i2ct_sync2 u_sync (
        .i_ref_clk(i_ref_clk),
        .i_sys_rst(i_sys_rst),
        .i_async({i_scl, i_sda}),
        .o_sync(pins_s)
    );
    assign scl_s = pins_s[1];
    assign sda_s = pins_s[0];

    wire scl_rise = scl_s & ~scl_q_ff;
    wire scl_fall = ~scl_s & scl_q_ff;
    wire bus_start = scl_s & scl_q_ff & sda_q_ff & ~sda_s;
    wire bus_stop = scl_s & scl_q_ff & ~sda_q_ff & sda_s;

    // ****************************************
    // state
    // ****************************************
    reg [2:0] state_ff, nxt_state;
    reg [3:0] cnt_ff, nxt_cnt;
    reg [7:0] sr_ff, nxt_sr;
    reg [7:0] tx_sr_ff, nxt_tx_sr;
    reg [7:0] buf_ff, nxt_buf;
    reg [7:0] addr_ff, nxt_addr;
    reg bf_ff, nxt_bf;
    reg irq_ff, nxt_irq;
    reg bcl_ff, nxt_bcl;
    reg ckp_ff, nxt_ckp;
    reg ack_status_bit_ff, nxt_ack_status_bit;
    reg ack_timing_flag_ff, nxt_ack_timing_flag;
    reg rw_ff, nxt_rw;
    reg da_ff, nxt_da;
    reg ua_ff, nxt_ua;
    reg s_ff, nxt_s;
    reg p_ff, nxt_p;
    reg ten_ok_ff, nxt_ten_ok;
    reg ack_en_ff, nxt_ack_en;
    reg ack_sw_ff, nxt_ack_sw;
    reg tx_drv_ff, nxt_tx_drv;
    reg scl_oe_n_ff, sda_oe_n_ff;
    reg pin_out_ff;

    wire active = (state_ff != ST_IDLE) && (state_ff != ST_WAIT);
    wire hi_match = (sr_ff[`I2CT_PFX_HI:`I2CT_PFX_LO] == `I2CT_TEN_PREFIX) &&
                    (sr_ff[`I2CT_A98_HI:`I2CT_A98_LO] == addr_ff[`I2CT_A98_HI:`I2CT_A98_LO]);
    // a ten-bit read header only matches once the full write address was seen
    wire adr_match = i_ten_bit_mode ?
                     (hi_match & (~sr_ff[`I2CT_RW_BIT] | ten_ok_ff)) :
                     (sr_ff[`I2CT_A7_HI:`I2CT_A7_LO] == addr_ff[`I2CT_A7_HI:`I2CT_A7_LO]);
    // under hold the software choice decides; otherwise every match is acked
    wire acked = ack_en_ff & ~(ack_sw_ff & i_ack_data_choice);
    wire hold_scl = ~ckp_ff | ua_ff;

    // ****************************************
    // next state
    // ****************************************
    always @* begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        nxt_sr = sr_ff;
        nxt_tx_sr = tx_sr_ff;
        nxt_buf = buf_ff;
        nxt_addr = addr_ff;
        nxt_bf = bf_ff;
        nxt_irq = irq_ff;
        nxt_bcl = bcl_ff;
        nxt_ckp = ckp_ff;
        nxt_ack_status_bit = ack_status_bit_ff;
        nxt_ack_timing_flag = ack_timing_flag_ff;
        nxt_rw = rw_ff;
        nxt_da = da_ff;
        nxt_ua = ua_ff;
        nxt_s = s_ff;
        nxt_p = p_ff;
        nxt_ten_ok = ten_ok_ff;
        nxt_ack_en = ack_en_ff;
        nxt_ack_sw = ack_sw_ff;
        nxt_tx_drv = tx_drv_ff;

        // software clears first so a same-cycle hardware set wins
        if (i_irq_clr) begin
            nxt_irq = 1'b0;
        end
        if (i_bcl_clr) begin
            nxt_bcl = 1'b0;
        end
        if (i_buf_rd) begin
            nxt_bf = 1'b0;
        end
        if (i_ckp_set) begin
            nxt_ckp = 1'b1;
        end
        if (i_addr_wr) begin
            nxt_addr = i_addr_wdata;
            nxt_ua = 1'b0;
        end
        if (i_buf_wr) begin
            nxt_buf = i_buf_wdata;
            nxt_tx_sr = i_buf_wdata;
            nxt_bf = 1'b1;
            // first bit goes out while the clock is still held low
            if ((state_ff == ST_TX) && (cnt_ff == `I2CT_CNT_ZERO)) begin
                nxt_tx_drv = ~i_buf_wdata[`I2CT_MSB];
            end
        end

        if (bus_start) begin
            nxt_state = ST_ADDR;
            nxt_cnt = `I2CT_CNT_ZERO;
            nxt_s = 1'b1;
            nxt_p = 1'b0;
            nxt_ack_en = 1'b0;
            nxt_tx_drv = 1'b0;
            if (i_start_irq_enable) begin
                nxt_irq = 1'b1;
            end
        end else if (bus_stop) begin
            nxt_state = ST_IDLE;
            nxt_cnt = `I2CT_CNT_ZERO;
            nxt_p = 1'b1;
            nxt_s = 1'b0;
            nxt_ten_ok = 1'b0;
            nxt_ack_en = 1'b0;
            nxt_tx_drv = 1'b0;
        end else if (active && scl_rise) begin
            if (cnt_ff < `I2CT_CNT_LAST) begin
                nxt_sr = {sr_ff[`I2CT_NEXT:0], sda_s};
                nxt_cnt = cnt_ff + `I2CT_CNT_ONE;
                // released a one but the line reads low: someone else won
                if ((state_ff == ST_TX) && ~tx_drv_ff && ~sda_s) begin
                    if (i_target_collision_detect_enable) begin
                        nxt_bcl = 1'b1;
                    end
                    nxt_state = ST_WAIT;
                    nxt_cnt = `I2CT_CNT_ZERO;
                end
            end else if (cnt_ff == `I2CT_CNT_LAST) begin
                nxt_cnt = `I2CT_CNT_ACK;
                if (state_ff == ST_TX) begin
                    nxt_ack_status_bit = sda_s;
                end
            end
        end else if (active && scl_fall) begin
            if (cnt_ff == `I2CT_CNT_LAST) begin
                nxt_ack_timing_flag = 1'b1;
                case (state_ff)
                    ST_ADDR: begin
                        if (adr_match) begin
                            nxt_rw = sr_ff[`I2CT_RW_BIT];
                            nxt_da = 1'b0;
                            nxt_buf = sr_ff;
                            nxt_bf = 1'b1;
                            nxt_ack_en = 1'b1;
                            if (i_address_hold_enable) begin
                                nxt_ckp = 1'b0;
                                nxt_irq = 1'b1;
                                nxt_ack_sw = 1'b1;
                            end
                        end else begin
                            nxt_state = ST_WAIT;
                            nxt_ack_timing_flag = 1'b0;
                        end
                    end
                    ST_ADDR_LO: begin
                        if (sr_ff == addr_ff) begin
                            nxt_buf = sr_ff;
                            nxt_bf = 1'b1;
                            nxt_ack_en = 1'b1;
                            nxt_ten_ok = 1'b1;
                            if (i_address_hold_enable) begin
                                nxt_ckp = 1'b0;
                                nxt_irq = 1'b1;
                                nxt_ack_sw = 1'b1;
                            end
                        end
                    end
                    ST_RX: begin
                        nxt_buf = sr_ff;
                        nxt_bf = 1'b1;
                        nxt_da = 1'b1;
                        nxt_ack_en = 1'b1;
                        if (i_data_hold_enable) begin
                            nxt_ckp = 1'b0;
                            nxt_irq = 1'b1;
                            nxt_ack_sw = 1'b1;
                        end
                    end
                    ST_TX: begin
                        nxt_tx_drv = 1'b0;
                        nxt_da = 1'b1;
                    end
                    default: begin
                        nxt_state = ST_WAIT;
                    end
                endcase
            end else if (cnt_ff == `I2CT_CNT_ACK) begin
                nxt_cnt = `I2CT_CNT_ZERO;
                nxt_ack_timing_flag = 1'b0;
                nxt_ack_en = 1'b0;
                nxt_ack_sw = 1'b0;
                case (state_ff)
                    ST_ADDR: begin
                        if (acked) begin
                            nxt_irq = 1'b1;
                            if (i_ten_bit_mode && ~rw_ff) begin
                                nxt_ua = 1'b1;
                                nxt_state = ST_ADDR_LO;
                            end else if (rw_ff) begin
                                nxt_ckp = 1'b0;
                                nxt_state = ST_TX;
                            end else begin
                                nxt_state = ST_RX;
                                if (i_clock_stretch_enable) begin
                                    nxt_ckp = 1'b0;
                                end
                            end
                        end else begin
                            nxt_state = ST_WAIT;
                        end
                    end
                    ST_ADDR_LO: begin
                        // mismatch still flags so software can restore the high byte
                        nxt_irq = 1'b1;
                        nxt_ua = 1'b1;
                        nxt_state = acked ? ST_RX : ST_WAIT;
                    end
                    ST_RX: begin
                        if (acked) begin
                            nxt_irq = 1'b1;
                            if (i_clock_stretch_enable) begin
                                nxt_ckp = 1'b0;
                            end
                        end else begin
                            nxt_state = ST_WAIT;
                        end
                    end
                    ST_TX: begin
                        nxt_irq = 1'b1;
                        if (~ack_status_bit_ff) begin
                            nxt_ckp = 1'b0;
                        end else begin
                            nxt_state = ST_WAIT;
                        end
                    end
                    default: begin
                        nxt_state = ST_WAIT;
                    end
                endcase
            end else if ((state_ff == ST_TX) && (cnt_ff != `I2CT_CNT_ZERO)) begin
                // data changes only while the clock is low
                nxt_tx_sr = {tx_sr_ff[`I2CT_NEXT:0], 1'b0};
                nxt_tx_drv = ~tx_sr_ff[`I2CT_NEXT];
            end
        end
        if (nxt_state == ST_WAIT) begin
            nxt_tx_drv = 1'b0;
            nxt_ack_en = 1'b0;
        end
    end

    // ****************************************
    // registers
    // ****************************************
    always @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            state_ff <= ST_IDLE;
            cnt_ff <= `I2CT_CNT_ZERO;
            sr_ff <= `I2CT_BYTE_RST;
            tx_sr_ff <= `I2CT_BYTE_RST;
            buf_ff <= `I2CT_BYTE_RST;
            addr_ff <= `I2CT_ADDR_RST;
            bf_ff <= `I2CT_FLAG_RST;
            irq_ff <= `I2CT_FLAG_RST;
            bcl_ff <= `I2CT_FLAG_RST;
            ckp_ff <= `I2CT_CKP_RST;
            ack_status_bit_ff <= `I2CT_FLAG_RST;
            ack_timing_flag_ff <= `I2CT_FLAG_RST;
            rw_ff <= `I2CT_FLAG_RST;
            da_ff <= `I2CT_FLAG_RST;
            ua_ff <= `I2CT_FLAG_RST;
            s_ff <= `I2CT_FLAG_RST;
            p_ff <= `I2CT_FLAG_RST;
            ten_ok_ff <= `I2CT_FLAG_RST;
            ack_en_ff <= `I2CT_FLAG_RST;
            ack_sw_ff <= `I2CT_FLAG_RST;
            tx_drv_ff <= `I2CT_FLAG_RST;
            scl_q_ff <= `I2CT_CKP_RST;
            sda_q_ff <= `I2CT_CKP_RST;
            scl_oe_n_ff <= `I2CT_OE_N_RST;
            sda_oe_n_ff <= `I2CT_OE_N_RST;
            pin_out_ff <= `I2CT_PIN_OUT;
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            sr_ff <= nxt_sr;
            tx_sr_ff <= nxt_tx_sr;
            buf_ff <= nxt_buf;
            addr_ff <= nxt_addr;
            bf_ff <= nxt_bf;
            irq_ff <= nxt_irq;
            bcl_ff <= nxt_bcl;
            ckp_ff <= nxt_ckp;
            ack_status_bit_ff <= nxt_ack_status_bit;
            ack_timing_flag_ff <= nxt_ack_timing_flag;
            rw_ff <= nxt_rw;
            da_ff <= nxt_da;
            ua_ff <= nxt_ua;
            s_ff <= nxt_s;
            p_ff <= nxt_p;
            ten_ok_ff <= nxt_ten_ok;
            ack_en_ff <= nxt_ack_en;
            ack_sw_ff <= nxt_ack_sw;
            tx_drv_ff <= nxt_tx_drv;
            scl_q_ff <= scl_s;
            sda_q_ff <= sda_s;
            // grab the clock only once it is already low, never cut a high phase
            scl_oe_n_ff <= ~(hold_scl & (~scl_s | ~scl_oe_n_ff));
            sda_oe_n_ff <= ~(acked | nxt_tx_drv);
            pin_out_ff <= `I2CT_PIN_OUT;
        end
    end

    assign o_scl_o = pin_out_ff;
    assign o_sda_o = pin_out_ff;
    assign o_scl_oe_n = scl_oe_n_ff;
    assign o_sda_oe_n = sda_oe_n_ff;
    assign o_rx_tx_buffer = buf_ff;
    assign o_buffer_full_flag = bf_ff;
    assign o_serial_irq_flag = irq_ff;
    assign o_bus_collision_flag = bcl_ff;
    assign o_clock_release_bit = ckp_ff;
    assign o_ack_status_bit = ack_status_bit_ff;
    assign o_ack_timing_flag = ack_timing_flag_ff;
    assign o_read_write_flag = rw_ff;
    assign o_data_address_flag = da_ff;
    assign o_update_address_flag = ua_ff;
    assign o_start_flag = s_ff;
    assign o_stop_flag = p_ff;
endmodule

//--- verif/i2ct_target_asserts.sv
module i2ct_target_asserts (
    input logic i_ref_clk,
    input logic i_sys_rst,
    input logic i_scl,
    input logic i_target_collision_detect_enable,
    input logic i_addr_wr,
    input logic i_buf_wr,
    input logic [7:0] i_buf_wdata,
    input logic i_buf_rd,
    input logic o_scl_oe_n,
    input logic o_sda_oe_n,
    input logic [7:0] o_rx_tx_buffer,
    input logic o_buffer_full_flag,
    input logic o_serial_irq_flag,
    input logic o_bus_collision_flag,
    input logic o_clock_release_bit,
    input logic o_ack_status_bit,
    input logic o_update_address_flag
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_sys_rst);
    // ****************
    // properties
    // ****************
    a_reset_values: assert property (
        disable iff (1'b0) i_sys_rst |=> o_clock_release_bit && !o_buffer_full_flag &&
        !o_serial_irq_flag && o_scl_oe_n && o_sda_oe_n) else $error("reset values wrong");
    a_bufwr_sets_full: assert property (
        i_buf_wr |=> o_buffer_full_flag && o_rx_tx_buffer == $past(i_buf_wdata))
        else $error("buffer write not taken");
    a_bufrd_clears_full: assert property (
        i_buf_rd && !i_buf_wr |=> !o_buffer_full_flag) else $error("buffer read kept full");
    // holding while the line is high would cut the host's high time short
    a_hold_after_low: assert property (
        $fell(o_scl_oe_n) |-> !$past(i_scl)) else $error("clock held while high");
    a_ua_release: assert property (
        o_update_address_flag && i_addr_wr |-> ##[1:2] o_scl_oe_n)
        else $error("address write did not free clock");
    a_coll_enable: assert property (
        $rose(o_bus_collision_flag) |-> $past(i_target_collision_detect_enable))
        else $error("collision flag while disabled");
    a_coll_quiet: assert property (
        $rose(o_bus_collision_flag) |-> o_sda_oe_n [*8]) else $error("drives after collision");
    a_ack_on_high: assert property (
        $rose(o_ack_status_bit) |-> i_scl && $past(i_scl)) else $error("ack taken off high");
endmodule

bind i2ct_target i2ct_target_asserts i2ct_target_asserts_inst (
    .i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_scl(i_scl),
    .i_target_collision_detect_enable(i_target_collision_detect_enable),
    .i_addr_wr(i_addr_wr), .i_buf_wr(i_buf_wr), .i_buf_wdata(i_buf_wdata),
    .i_buf_rd(i_buf_rd), .o_scl_oe_n(o_scl_oe_n), .o_sda_oe_n(o_sda_oe_n),
    .o_rx_tx_buffer(o_rx_tx_buffer), .o_buffer_full_flag(o_buffer_full_flag),
    .o_serial_irq_flag(o_serial_irq_flag), .o_bus_collision_flag(o_bus_collision_flag),
    .o_clock_release_bit(o_clock_release_bit), .o_ack_status_bit(o_ack_status_bit),
    .o_update_address_flag(o_update_address_flag)
);

//--- verif/i2ct_host_model.sv
module i2ct_host_model (
    input logic i_scl,
    input logic i_sda,
    output logic o_scl_rel,
    output logic o_sda_rel
);
    timeunit 1ns;
    timeprecision 1ps;
    int hp = 80;
    logic [7:0] rd_byte;
    event got;
    initial begin
        o_scl_rel = 1'b1;
        o_sda_rel = 1'b1;
    end
    // ****************
    // bus phases
    // ****************
    // data moves 20 ns after the fall so a slow sampler never sees a false start
    task automatic bit_io(input logic b, output logic s);
        #20 o_sda_rel = b;
        #(hp - 20) o_scl_rel = 1'b1;
        wait (i_scl === 1'b1);
        #(hp / 2) s = i_sda;
        #(hp / 2) o_scl_rel = 1'b0;
    endtask
    task automatic h_start();
        #20 o_sda_rel = 1'b1;
        #(hp) o_scl_rel = 1'b1;
        wait (i_scl === 1'b1);
        #(hp) o_sda_rel = 1'b0;
        #(hp) o_scl_rel = 1'b0;
    endtask
    task automatic h_stop();
        #20 o_sda_rel = 1'b0;
        #(hp) o_scl_rel = 1'b1;
        wait (i_scl === 1'b1);
        #(hp) o_sda_rel = 1'b1;
        #(hp);
    endtask
    task automatic h_write(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_io(b[i], s);
        bit_io(1'b1, ack);
    endtask
    // jam pulls data low on every data bit to provoke a collision
    task automatic h_read(input logic ack, input logic jam, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) bit_io(~jam, b[i]);
        bit_io(ack, s);
        rd_byte = b;
        ->got;
    endtask
endmodule

//--- verif/test_i2ct_target.sv
module test_i2ct_target;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int LIMIT = 40000;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [6:0] cfg = 7'h00; // ackd sie cde data_hold_enable address_hold_enable sen ten
    logic [5:0] st = 6'h00; // bclclr irqclr ckpset bufrd bufwr addrwr
    logic [7:0] awd = 8'h00;
    logic [7:0] bwd = 8'h00;
    wire scl, sda, scl_oe_n, sda_oe_n, scl_rel, sda_rel, scl_o, sda_o;
    wire bf, irq, bcl, clock_release_bit, acks, ackt, rw, da, ua, sflag, pflag;
    wire [7:0] buf_q;
    int n_fail = 0;
    int checks = 0;
    int cyc = 0;
    logic [7:0] exp_q[$];
    logic ack;
    logic [7:0] d, rb;
    always #2 clk = ~clk;
    // both lines are pulled up; any party may pull low
    assign scl = scl_rel & (scl_oe_n | scl_o);
    assign sda = sda_rel & (sda_oe_n | sda_o);
    i2ct_target i2ct_target_inst (
        .i_ref_clk(clk), .i_sys_rst(rst), .i_scl(scl), .i_sda(sda),
        .i_ten_bit_mode(cfg[0]), .i_clock_stretch_enable(cfg[1]),
        .i_address_hold_enable(cfg[2]), .i_data_hold_enable(cfg[3]),
        .i_target_collision_detect_enable(cfg[4]), .i_start_irq_enable(cfg[5]),
        .i_ack_data_choice(cfg[6]), .i_addr_wr(st[0]), .i_addr_wdata(awd),
        .i_buf_wr(st[1]), .i_buf_wdata(bwd), .i_buf_rd(st[2]), .i_ckp_set(st[3]),
        .i_irq_clr(st[4]), .i_bcl_clr(st[5]), .o_scl_o(scl_o), .o_scl_oe_n(scl_oe_n),
        .o_sda_o(sda_o), .o_sda_oe_n(sda_oe_n), .o_rx_tx_buffer(buf_q),
        .o_buffer_full_flag(bf), .o_serial_irq_flag(irq), .o_bus_collision_flag(bcl),
        .o_clock_release_bit(clock_release_bit), .o_ack_status_bit(acks), .o_ack_timing_flag(ackt),
        .o_read_write_flag(rw), .o_data_address_flag(da), .o_update_address_flag(ua),
        .o_start_flag(sflag), .o_stop_flag(pflag)
    );
    i2ct_host_model host_inst (.i_scl(scl), .i_sda(sda), .o_scl_rel(scl_rel),
        .o_sda_rel(sda_rel));
    // ****************
    // helpers
    // ****************
    task automatic chk_bit(input string nm, input logic e, input logic g);
        checks++;
        if (g !== e) begin
            n_fail++;
            $display("[FAIL] %s expected %b seen %b", nm, e, g);
        end
    endtask
    task automatic chk_byte(input string nm, input logic [7:0] e, input logic [7:0] g);
        checks++;
        if (g !== e) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic sw(input logic [5:0] m);
        @(posedge clk) st <= m;
        @(posedge clk) st <= 6'h00;
    endtask
    task automatic settle();
        repeat (8) @(posedge clk);
        @(negedge clk);
    endtask
    // ckp set rides along so a stretch after an address byte is always freed
    task automatic set_addr(input logic [7:0] a);
        @(posedge clk) awd <= a;
        sw(6'h09);
    endtask
    task automatic load(input logic [7:0] v);
        @(posedge clk) bwd <= v;
        sw(6'h02);
        @(negedge clk);
    endtask
    task automatic report_and_stop();
        if (n_fail == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    always @(host_inst.got) chk_byte("host_rd", exp_q.pop_front(), host_inst.rd_byte);
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            n_fail++;
            report_and_stop();
        end
    end
    // ****************
    // scenarios
    // ****************
    initial begin
        void'($urandom(32'hDA00));
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        chk_bit("bf", 1'b0, bf);
        chk_bit("ckp", 1'b1, clock_release_bit);
        @(posedge clk) cfg <= 7'h20;
        set_addr(8'hB4);
        host_inst.h_start();
        settle();
        chk_bit("start", 1'b1, sflag);
        chk_bit("irq", 1'b1, irq);
        sw(6'h10);
        host_inst.h_write(8'hB5, ack);
        chk_bit("ack", 1'b0, ack);
        settle();
        chk_bit("irq", 1'b1, irq);
        chk_bit("ckp", 1'b0, clock_release_bit);
        chk_bit("rw", 1'b1, rw);
        sw(6'h14);
        @(negedge clk);
        chk_bit("bf", 1'b0, bf);
        for (int k = 0; k < 2; k++) begin
            d = 8'($urandom);
            load(d);
            chk_bit("bf", 1'b1, bf);
            exp_q.push_back(d);
            sw(6'h08);
            host_inst.h_read(k[0], 1'b0, rb);
            settle();
            chk_bit("acks", k[0], acks);
            chk_bit("irq", 1'b1, irq);
            chk_bit("ckp", k[0], clock_release_bit);
            sw(6'h10);
        end
        host_inst.h_stop();
        @(negedge clk);
        chk_bit("stop", 1'b1, pflag);
        for (int e = 0; e < 2; e++) begin
            @(posedge clk) cfg <= e[0] ? 7'h10 : 7'h00;
            host_inst.h_start();
            host_inst.h_write(8'hB5, ack);
            settle();
            sw(6'h14);
            load(8'hFF);
            exp_q.push_back(8'h00);
            sw(6'h08);
            host_inst.h_read(1'b1, 1'b1, rb);
            settle();
            chk_bit("bcl", e[0], bcl);
            chk_bit("sda_oe_n", 1'b1, sda_oe_n);
            chk_bit("ckp", 1'b1, clock_release_bit);
            sw(6'h30);
            host_inst.h_stop();
        end
        for (int a = 0; a < 2; a++) begin
            @(posedge clk) cfg <= {a[0], 6'h04};
            sw(6'h10);
            host_inst.h_start();
            settle();
            chk_bit("irq", 1'b0, irq);
            fork
                host_inst.h_write(8'hB5, ack);
                begin
                    wait (irq === 1'b1);
                    @(negedge clk);
                    chk_bit("ckp", 1'b0, clock_release_bit);
                    chk_bit("ackt", 1'b1, ackt);
                    chk_bit("da", 1'b0, da);
                    sw(6'h14);
                    sw(6'h08);
                end
            join
            chk_bit("ack", a[0], ack);
            settle();
            chk_bit("irq", ~a[0], irq);
            chk_bit("ckp", a[0], clock_release_bit);
            if (a == 0) begin
                sw(6'h14);
                d = 8'($urandom);
                load(d);
                exp_q.push_back(d);
                sw(6'h08);
                host_inst.h_read(1'b1, 1'b0, rb);
            end
            host_inst.h_stop();
        end
        @(posedge clk) cfg <= 7'h0B;
        set_addr(8'hF4);
        sw(6'h10);
        host_inst.h_start();
        host_inst.h_write(8'hF4, ack);
        chk_bit("ack", 1'b0, ack);
        settle();
        chk_bit("ua", 1'b1, ua);
        chk_bit("irq", 1'b1, irq);
        chk_bit("scl_oe_n", 1'b0, scl_oe_n);
        sw(6'h14);
        set_addr(8'h3C);
        host_inst.h_write(8'h3C, ack);
        settle();
        chk_bit("ua", 1'b1, ua);
        sw(6'h14);
        set_addr(8'hF4);
        d = 8'($urandom);
        // data hold stretches at the eighth fall; release it from the side
        fork
            host_inst.h_write(d, ack);
            begin
                wait (irq === 1'b1);
                @(negedge clk);
                chk_bit("ckp", 1'b0, clock_release_bit);
                sw(6'h18);
            end
        join
        settle();
        chk_byte("rx_buf", d, buf_q);
        chk_bit("ckp", 1'b0, clock_release_bit);
        sw(6'h1C);
        host_inst.h_start();
        host_inst.h_write(8'hF4, ack);
        settle();
        sw(6'h14);
        set_addr(8'h3C);
        host_inst.h_write(8'h3D, ack);
        chk_bit("ack", 1'b1, ack);
        settle();
        chk_bit("ua", 1'b1, ua);
        chk_bit("irq", 1'b1, irq);
        chk_bit("bf", 1'b0, bf);
        chk_bit("ckp", 1'b1, clock_release_bit);
        set_addr(8'hF4);
        host_inst.h_stop();
        report_and_stop();
    end
endmodule
